//--- common/nvbm_pkg.sv
// package for the host-side controller of a byte memory with a nonvolatile shadow
// assumes a 125 MHz clk_i; the memory pins are asynchronous to it
// What this block and the memory device do
// R1 - host presents a 15-bit address selecting one of 32,768 bytes
// R2 - one shared 8-bit bus; host drives on writes, device on enabled reads
// R3 - device acts only while its active-low chip select is low
// R4 - write strobe low stores bus byte at address latched by select fall
// R5 - device drives data only while active-low output enable is low
// R6 - device holds busy low for the whole save, releases afterward
// R7 - pulling busy low from outside requests a save from the device
// R8 - device saves automatically when power loss is detected
// R9 - device restores contents automatically at power-up before accesses
// R10 - save and restore may also be started by host software; this host starts only a save, via save_req_i, never a restore
// R11 - host starts no access while busy shows a save or restore
package nvbm_pkg;
  // --------------------------------------------------------------
  // geometry
  // --------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  // --------------------------------------------------------------
  // timing, in ns, and derived cycle counts
  // --------------------------------------------------------------
  localparam int CLK_NS    = 8;
  localparam int SETUP_NS  = 16;   // address/select setup before strobe
  localparam int STROBE_NS = 48;   // strobe width, covers slowest grade
  localparam int HOLD_NS   = 16;   // release hold after strobe
  localparam int SETUP_CYC  = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC   = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int REQ_NS     = 40;  // width of a save request pulse on busy
  localparam int REQ_CYC    = (REQ_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W      = 4;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
endpackage

//--- hw/nvbm_sync.sv
// two-flop synchroniser for one level from the pins
// assumes the input is asynchronous to clk_i
`timescale 1ns/100ps
module nvbm_sync (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_r;
  // first stage read only by the second; reset high as the pin idles high
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= 1'b1;
      q_o    <= 1'b1;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule

//--- hw/nvbm_host.sv
// host controller driving the nonvolatile-backed byte memory pins
// assumes the memory sits directly on these pins and busy has a pull-up
`timescale 1ns/100ps
module nvbm_host (
  input  wire logic                         clk_i,
  input  wire logic                         rst_n_i,
  // user side
  input  wire logic                         req_valid_i,
  input  wire logic                         req_write_i,
  input  wire logic [nvbm_pkg::ADDR_W-1:0]  req_addr_i,
  input  wire logic [nvbm_pkg::DATA_W-1:0]  req_wdata_i,
  output logic                              req_ready_o,
  input  wire logic                         save_req_i,
  output logic                              rsp_valid_o,
  output logic [nvbm_pkg::DATA_W-1:0]       rsp_rdata_o,
  output logic                              nv_busy_o,
  // memory pins
  output logic [nvbm_pkg::ADDR_W-1:0]       byte_sel_o,
  output logic                              chip_sel_n_o,
  output logic                              out_en_n_o,
  output logic                              wr_en_n_o,
  input  wire logic [nvbm_pkg::DATA_W-1:0]  data_pins_i,
  output logic [nvbm_pkg::DATA_W-1:0]       data_pins_o,
  output logic                              data_pins_oe_o,
  input  wire logic                         nv_busy_n_i,
  output logic                              nv_busy_n_o,
  output logic                              nv_busy_n_oe_o
);

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef enum logic [2:0] {NVBM_IDLE, NVBM_SETUP, NVBM_STROBE, NVBM_HOLD, NVBM_SAVE} nvbm_state_e;

  nvbm_state_e                  state_r;
  logic [nvbm_pkg::CNT_W-1:0]   cnt_r;
  logic                         wr_r;
  logic                         busy_s;
  logic [nvbm_pkg::DATA_W-1:0]  rd_s1_r;
  logic [nvbm_pkg::DATA_W-1:0]  rd_s2_r;

  // busy pin synchronised before any use
  nvbm_sync u_busy_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (nv_busy_n_i),
    .q_o     (busy_s)
  );

  // read data sampled through two flops; stable long before strobe ends
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_s1_r <= 8'h00;
      rd_s2_r <= 8'h00;
    end else begin
      rd_s1_r <= data_pins_i;
      rd_s2_r <= rd_s1_r;
    end
  end

  // accepted only when idle and the memory is not saving or restoring
  assign req_ready_o = (state_r == NVBM_IDLE) && busy_s && !save_req_i; // R11
  assign nv_busy_o   = !busy_s;

  // --------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= NVBM_IDLE;
      cnt_r   <= nvbm_pkg::CNT_ZERO;
      wr_r    <= 1'b0;
    end else begin
      case (state_r)
        NVBM_IDLE: begin
          if (save_req_i && busy_s) begin
            state_r <= NVBM_SAVE; // R7 R10
            cnt_r   <= nvbm_pkg::CNT_W'(nvbm_pkg::REQ_CYC);
          end else if (req_valid_i && req_ready_o) begin
            state_r <= NVBM_SETUP;
            wr_r    <= req_write_i;
            cnt_r   <= nvbm_pkg::CNT_W'(nvbm_pkg::SETUP_CYC);
          end
        end
        NVBM_SETUP: begin
          if (cnt_r == nvbm_pkg::CNT_ONE) begin
            state_r <= NVBM_STROBE;
            cnt_r   <= nvbm_pkg::CNT_W'(nvbm_pkg::STROBE_CYC);
          end else begin
            cnt_r <= cnt_r - nvbm_pkg::CNT_ONE;
          end
        end
        NVBM_STROBE: begin
          if (cnt_r == nvbm_pkg::CNT_ONE) begin
            state_r <= NVBM_HOLD;
            cnt_r   <= nvbm_pkg::CNT_W'(nvbm_pkg::HOLD_CYC);
          end else begin
            cnt_r <= cnt_r - nvbm_pkg::CNT_ONE;
          end
        end
        NVBM_HOLD: begin
          if (cnt_r == nvbm_pkg::CNT_ONE) begin
            state_r <= NVBM_IDLE;
          end else begin
            cnt_r <= cnt_r - nvbm_pkg::CNT_ONE;
          end
        end
        NVBM_SAVE: begin
          // pulse then return; device then holds busy low itself
          if (cnt_r == nvbm_pkg::CNT_ONE) begin
            state_r <= NVBM_IDLE;
          end else begin
            cnt_r <= cnt_r - nvbm_pkg::CNT_ONE;
          end
        end
        default: state_r <= NVBM_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // pins, all from flops except the busy drive value, tied low
  // --------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      byte_sel_o     <= 15'h0000;
      data_pins_o    <= 8'h00;
    end else if (state_r == NVBM_IDLE && req_valid_i && req_ready_o && !save_req_i) begin
      byte_sel_o  <= req_addr_i; // R1
      data_pins_o <= req_wdata_i;
    end
  end

  // select framing whole access; address latched on its fall
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chip_sel_n_o   <= 1'b1;
      wr_en_n_o      <= 1'b1;
      out_en_n_o     <= 1'b1;
      data_pins_oe_o <= 1'b0;
    end else begin
      chip_sel_n_o   <= !((state_r == NVBM_SETUP && cnt_r != nvbm_pkg::CNT_ONE) || state_r == NVBM_STROBE
                          || (state_r == NVBM_SETUP)); // R3
      wr_en_n_o      <= !(wr_r && ((state_r == NVBM_SETUP && cnt_r == nvbm_pkg::CNT_ONE)
                          || (state_r == NVBM_STROBE && cnt_r != nvbm_pkg::CNT_ONE))); // R4
      out_en_n_o     <= !(!wr_r && ((state_r == NVBM_SETUP && cnt_r == nvbm_pkg::CNT_ONE)
                          || (state_r == NVBM_STROBE && cnt_r != nvbm_pkg::CNT_ONE))); // R5
      // host drives data only during write frame, never with output enable
      data_pins_oe_o <= wr_r && (state_r == NVBM_SETUP || state_r == NVBM_STROBE); // R2
    end
  end

  // read response at end of strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= 8'h00;
    end else begin
      rsp_valid_o <= !wr_r && state_r == NVBM_STROBE && cnt_r == nvbm_pkg::CNT_ONE;
      if (!wr_r && state_r == NVBM_STROBE && cnt_r == nvbm_pkg::CNT_ONE) begin
        rsp_rdata_o <= rd_s2_r;
      end
    end
  end

  // open drain: only ever pull low
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nv_busy_n_oe_o <= 1'b0;
    end else begin
      nv_busy_n_oe_o <= (state_r == NVBM_SAVE); // R7
    end
  end
  assign nv_busy_n_o = 1'b0;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  property p_no_start_busy;
    @(posedge clk_i) disable iff (!rst_n_i) (state_r == NVBM_IDLE && !busy_s) |=> state_r != NVBM_SETUP;
  endproperty
  a_no_start_busy: assert property (p_no_start_busy) else $error("access started while busy"); // R11

  property p_no_contention;
    @(posedge clk_i) disable iff (!rst_n_i) !(data_pins_oe_o && !out_en_n_o);
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("bus driven during read"); // R2

  property p_strobe_in_sel;
    @(posedge clk_i) disable iff (!rst_n_i) (!wr_en_n_o || !out_en_n_o) |-> !chip_sel_n_o;
  endproperty
  a_strobe_in_sel: assert property (p_strobe_in_sel) else $error("strobe outside select"); // R3

  property p_wr_width;
    @(posedge clk_i) disable iff (!rst_n_i) $fell(wr_en_n_o) |-> !wr_en_n_o [*6] ##1 wr_en_n_o;
  endproperty
  a_wr_width: assert property (p_wr_width) else $error("write strobe width wrong"); // R4

  property p_data_during_wr;
    @(posedge clk_i) disable iff (!rst_n_i) !wr_en_n_o |-> data_pins_oe_o && $stable(data_pins_o);
  endproperty
  a_data_during_wr: assert property (p_data_during_wr) else $error("write data not held"); // R4

  property p_addr_stable;
    @(posedge clk_i) disable iff (!rst_n_i) !chip_sel_n_o && !$rose(chip_sel_n_o) && !$past(chip_sel_n_o)
      |-> $stable(byte_sel_o);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved in access"); // R1

  property p_save_pulse;
    @(posedge clk_i) disable iff (!rst_n_i) $rose(nv_busy_n_oe_o) |-> nv_busy_n_oe_o [*5] ##1 !nv_busy_n_oe_o;
  endproperty
  a_save_pulse: assert property (p_save_pulse) else $error("save request pulse width wrong"); // R7

  property p_rsp_read;
    @(posedge clk_i) disable iff (!rst_n_i) $rose(out_en_n_o) |-> ##[0:2] rsp_valid_o;
  endproperty
  a_rsp_read: assert property (p_rsp_read) else $error("read without response"); // R5

  c_write: cover property (@(posedge clk_i) disable iff (!rst_n_i) $fell(wr_en_n_o));
  c_read:  cover property (@(posedge clk_i) disable iff (!rst_n_i) rsp_valid_o);
  c_save:  cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(nv_busy_n_oe_o));
  c_busy:  cover property (@(posedge clk_i) disable iff (!rst_n_i) nv_busy_o && req_valid_i);
endmodule

//--- verification/nvbm_mem_model.sv
// behavioural model of the byte memory with nonvolatile shadow
// assumes the bench resolves data and busy wires from both parties
`timescale 1ns/100ps
module nvbm_mem_model #(
  parameter int SAVE_NS    = 400,
  parameter int RESTORE_NS = 400
) (
  input  wire logic [nvbm_pkg::ADDR_W-1:0] byte_sel_i,
  input  wire logic                        chip_sel_n_i,
  input  wire logic                        out_en_n_i,
  input  wire logic                        wr_en_n_i,
  input  wire logic [nvbm_pkg::DATA_W-1:0] data_pins_i,
  input  wire logic                        nv_busy_n_i,
  input  wire logic                        pwr_fail_i,
  output logic [nvbm_pkg::DATA_W-1:0]      data_pins_o,
  output logic                             data_pins_oe_o,
  output logic                             busy_pull_o,
  output int                               save_cnt_o
);
  // ------------------------------------------------------------
  // array, restore, save
  // ------------------------------------------------------------
  logic [7:0]  mem_r [0:32767];
  logic [14:0] addr_r;
  initial begin
    save_cnt_o  = 0;
    busy_pull_o = 1'b1;
    #RESTORE_NS;
    busy_pull_o = 1'b0;
  end
  // sampled just after the fall: the controller sets the address one edge before select falls
  always @(negedge chip_sel_n_i) #1 addr_r = byte_sel_i;
  // store whatever stands on the bus while the strobe is low
  always @(chip_sel_n_i or wr_en_n_i or data_pins_i) begin
    if (!chip_sel_n_i && !wr_en_n_i && !busy_pull_o) mem_r[addr_r] = data_pins_i;
  end
  assign data_pins_oe_o = !chip_sel_n_i && !out_en_n_i && wr_en_n_i;
  assign data_pins_o    = mem_r[addr_r];
  // outside pull or power loss starts a save; busy held low all through
  always @(negedge nv_busy_n_i or posedge pwr_fail_i) begin
    if (!busy_pull_o) begin
      busy_pull_o = 1'b1;
      save_cnt_o++;
      #SAVE_NS busy_pull_o = 1'b0;
    end
  end
endmodule

//--- verification/nvbm_host_tb_top.sv
// self-checking bench for the memory host controller
// assumes the memory model on the far side of the pins
`timescale 1ns/100ps
module nvbm_host_tb_top;
  // ------------------------------------------------------------
  // stimulus, wires, instances
  // ------------------------------------------------------------
  logic       clk_i = 1'b0, rst_n_i = 1'b0, req_valid_i = 1'b0, req_write_i = 1'b0;
  logic       save_req_i = 1'b0, pwr_fail = 1'b0;
  logic [14:0] req_addr_i = 15'h0000, byte_sel;
  logic [7:0] req_wdata_i = 8'h00, rsp_rdata_o, h_do, m_do, last_r = 8'h00;
  logic       req_ready_o, rsp_valid_o, nv_busy_o, cs_n, oe_n, we_n, h_oe, m_oe, hb_do, hb_oe, m_pull;
  int         bad_count = 0, compares = 0, cyc = 0, saves;
  // undriven bus shows the inverse of its last value; busy has a pull-up
  wire [7:0] data_w = h_oe ? h_do : (m_oe ? m_do : ~last_r);
  wire       busy_w = !((hb_oe && !hb_do) || m_pull);
  nvbm_host uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_write_i(req_write_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o), .save_req_i(save_req_i),
    .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .nv_busy_o(nv_busy_o), .byte_sel_o(byte_sel),
    .chip_sel_n_o(cs_n), .out_en_n_o(oe_n), .wr_en_n_o(we_n), .data_pins_i(data_w), .data_pins_o(h_do),
    .data_pins_oe_o(h_oe), .nv_busy_n_i(busy_w), .nv_busy_n_o(hb_do), .nv_busy_n_oe_o(hb_oe));
  nvbm_mem_model u_mem (.byte_sel_i(byte_sel), .chip_sel_n_i(cs_n), .out_en_n_i(oe_n), .wr_en_n_i(we_n),
    .data_pins_i(data_w), .nv_busy_n_i(busy_w), .pwr_fail_i(pwr_fail), .data_pins_o(m_do),
    .data_pins_oe_o(m_oe), .busy_pull_o(m_pull), .save_cnt_o(saves));
  initial forever #4 clk_i = ~clk_i;
  // cut a hang short; the whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cyc++;
    if (h_oe || m_oe) last_r <= data_w;
    if (cyc == 3000) begin
      bad_count++;
      stop_test();
    end
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wait_busy(input logic lvl);
    int n = 0;
    do @(negedge clk_i); while (nv_busy_o !== lvl && ++n < 100);
    chk({7'h00, nv_busy_o}, {7'h00, lvl}, "busy flag");
  endtask
  // one access; reads are judged against the expected byte
  task automatic access(input logic wr, input logic [14:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_write_i <= wr;
    req_addr_i  <= a;
    req_wdata_i <= d;
    do @(negedge clk_i); while (req_ready_o !== 1'b1 && ++n < 50);
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    n = 0;
    if (!wr) begin
      do @(negedge clk_i); while (rsp_valid_o !== 1'b1 && ++n < 20);
      chk(rsp_rdata_o, d, "read data");
    end
  endtask
  task automatic t_restore();
    repeat (3) @(negedge clk_i);
    chk({7'h00, nv_busy_o}, 8'h01, "restore busy");
    chk({7'h00, req_ready_o}, 8'h00, "ready in restore");
    wait_busy(1'b0);
    chk({7'h00, req_ready_o}, 8'h01, "ready after restore");
    $display("done restore");
  endtask
  task automatic t_rw();
    logic [14:0] a[4] = '{15'h0000, 15'h7fff, 15'h2aaa, 15'h5555};
    logic [7:0]  d[4] = '{8'h5a, 8'ha5, 8'h00, 8'hff};
    for (int i = 0; i < 4; i++) access(1'b1, a[i], d[i]);
    for (int i = 0; i < 4; i++) access(1'b0, a[i], d[i]);
    $display("done read write");
  endtask
  // save request, then an access refused while busy
  task automatic t_save();
    int n = 0;
    int s0 = saves;
    @(posedge clk_i);
    save_req_i <= 1'b1;
    do @(negedge clk_i); while (busy_w !== 1'b0 && ++n < 20);
    @(posedge clk_i);
    save_req_i  <= 1'b0;
    req_valid_i <= 1'b1;
    repeat (4) @(negedge clk_i);
    chk({7'h00, nv_busy_o}, 8'h01, "save busy");
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_i);
      chk({7'h00, cs_n}, 8'h01, "select during save");
    end
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    wait_busy(1'b0);
    chk(8'(saves - s0), 8'h01, "save count");
    access(1'b0, 15'h7fff, 8'ha5);
    $display("done save");
  endtask
  task automatic t_pwrfail();
    int s0 = saves;
    @(posedge clk_i);
    pwr_fail <= 1'b1;
    @(posedge clk_i);
    pwr_fail <= 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
    chk(8'(saves - s0), 8'h01, "power loss save");
    access(1'b0, 15'h2aaa, 8'h00);
    $display("done power loss");
  endtask
  // reset cuts a read in mid-select; pins must fall idle at once and no stale answer follow
  task automatic t_reset();
    int n = 0;
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_write_i <= 1'b0;
    req_addr_i  <= 15'h0000;
    do @(negedge clk_i); while (cs_n !== 1'b0 && ++n < 30);
    @(posedge clk_i);
    rst_n_i     <= 1'b0;
    req_valid_i <= 1'b0;
    @(negedge clk_i);
    chk({5'h00, cs_n, oe_n, we_n}, 8'h07, "strobes in reset");
    chk({6'h00, h_oe, hb_oe}, 8'h00, "drivers in reset");
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    chk({7'h00, rsp_valid_o}, 8'h00, "answer after reset");
    access(1'b0, 15'h0000, 8'h5a);
    $display("done reset");
  endtask
  task automatic stop_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_restore();
    t_rw();
    t_save();
    t_pwrfail();
    t_reset();
    stop_test();
  end
endmodule
